// ### logic/dust_seq_pkg.sv
package dust_seq_pkg;
    // timebase: core clock 20 MHz, control tick every 10 ms
    localparam int CLK_NS = 50;
    localparam int TICK_NS = 10_000_000;
    localparam int TICK_CYCLES_DEF = TICK_NS / CLK_NS;
    localparam logic [16:0] TICKS_PER_SEC = 17'h00064;
    localparam logic [16:0] TIMEOUT_SEC = 17'h0012c;
    localparam logic [16:0] TIMEOUT_TICKS = 17'(TIMEOUT_SEC * TICKS_PER_SEC);
    localparam logic [9:0] RANGE_TOP = 10'h3e7;
    localparam logic [4:0] NUM_OUT = 5'h10;
    localparam logic [3:0] NUM_PRM = 4'hd;

    // parameter slots, also their register index
    localparam logic [3:0] F_CONSENT = 4'h0;
    localparam logic [3:0] F_PULSE = 4'h1;
    localparam logic [3:0] F_PAUSE = 4'h2;
    localparam logic [3:0] F_COUNT = 4'h3;
    localparam logic [3:0] F_POST = 4'h4;
    localparam logic [3:0] F_MANUAL = 4'h5;
    localparam logic [3:0] F_PCTL = 4'h6;
    localparam logic [3:0] F_VOLT = 4'h7;
    localparam logic [3:0] F_ZERO = 4'h8;
    localparam logic [3:0] F_STOP = 4'h9;
    localparam logic [3:0] F_START = 4'ha;
    localparam logic [3:0] F_MAX = 4'hb;
    localparam logic [3:0] F_FAN = 4'hc;
    localparam logic [3:0] REG_STATUS = 4'hd;
    localparam logic [3:0] REG_MASK = 4'he;
    localparam logic [3:0] REG_STATE = 4'hf;

    // limits and reset values, slot 12 first
    localparam logic [12:0][9:0] PRM_LO = {10'h000, 10'h001, 10'h001,
        10'h001, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000,
        10'h001, 10'h005, 10'h000};
    localparam logic [12:0][9:0] PRM_HI = {10'h001, 10'h3e7, 10'h3e7,
        10'h3e7, 10'h3e7, 10'h000, 10'h001, 10'h000, 10'h063, 10'h010,
        10'h3e7, 10'h1f4, 10'h001};
    localparam logic [12:0][9:0] PRM_RST = {10'h000, 10'h12c, 10'h096,
        10'h064, 10'h000, 10'h000, 10'h000, 10'h000, 10'h00a, 10'h010,
        10'h00a, 10'h00a, 10'h000};

    // status and mask bit positions
    localparam int ST_PULSE = 0;
    localparam int ST_MAXA = 1;
    localparam int ST_OVL = 2;
    localparam int ST_HALT = 3;

    typedef enum logic [1:0] {MODE_RUN, MODE_MENU, MODE_EDIT} mode_t;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_PULSE, SEQ_PAUSE} seq_t;
    typedef enum logic [1:0] {DSP_RUN, DSP_OFF, DSP_FANOFF, DSP_LOWDP} disp_t;

    typedef struct packed {
        logic keyA;
        logic keyB;
        logic keyC;
    } keys_t;

    typedef struct packed {
        disp_t dispState;
        logic postBlink;
        logic lowBlink;
        logic alarmMax;
        logic alarmOvl;
        logic [4:0] ovlNum;
        logic [4:0] firedNum;
        logic overRange;
        logic [9:0] pressure;
        logic [16:0] pauseTicks;
    } indicator_t;

    typedef struct packed {
        keys_t keyS1;
        keys_t keyS2;
        keys_t keyS3;
        logic [1:0] conS;
        logic [1:0] fanS;
        logic [15:0] ovlS1;
        logic [15:0] ovlS2;
        logic [9:0] rawS1;
        logic [9:0] rawS2;
        logic [23:0] tickCnt;
        mode_t mode;
        logic [3:0] func;
        logic [16:0] idle;
        seq_t seq;
        logic [16:0] phase;
        logic [3:0] curOut;
        logic manual;
        logic manReq;
        logic [3:0] manSel;
        logic [15:0] valve;
        logic fanWas;
        logic [6:0] postLeft;
        logic pressLow;
        indicator_t ind;
        logic [12:0][9:0] prm;
        logic [3:0] status;
        logic [3:0] mask;
        logic [15:0] rdData;
    } state_t;

    // bring a written value into the slot's legal range
    function automatic logic [9:0] clampPrm(logic [3:0] idx, logic [9:0] v);
        if (v < PRM_LO[idx]) return PRM_LO[idx];
        if (v > PRM_HI[idx]) return PRM_HI[idx];
        return v;
    endfunction : clampPrm

    // next output index with wrap at the active count
    function automatic logic [3:0] nextOut(logic [3:0] cur, logic [4:0] lim);
        return (5'(cur) + 5'h1 >= lim) ? 4'h0 : cur + 4'h1;
    endfunction : nextOut
endpackage : dust_seq_pkg

// ### logic/dust_filter_cleaning_sequencer.sv
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module dust_filter_cleaning_sequencer #(
    parameter int TICK_CYCLES = dust_seq_pkg::TICK_CYCLES_DEF
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    // field pins
    input wire dust_seq_pkg::keys_t keyPins,
    input wire logic consentPin,
    input wire logic fanContactPin,
    input wire logic [15:0] overloadPins,
    input wire logic [9:0] pressureRaw,
    // valve drive
    output logic [15:0] valveOut,
    // display and alarms
    output dust_seq_pkg::indicator_t ind,
    output dust_seq_pkg::mode_t menuMode,
    output logic [3:0] menuFunc,
    output logic irq
);
    dust_seq_pkg::state_t s;
    dust_seq_pkg::state_t n;

    logic tick;
    logic kA;
    logic kB;
    logic kC;
    logic [9:0] p;
    logic [4:0] cnt;
    logic [4:0] manLim;
    logic consentOk;
    logic fanOn;
    logic runOk;
    logic pulseDone;
    logic pauseDone;
    logic [16:0] pauseLen;
    logic [3:0] startIdx;
    logic ovlHit;

    // timebase and key edges from the synchronised key levels
    assign tick = s.tickCnt == 24'(TICK_CYCLES - 1);
    assign kA = s.keyS2.keyA & ~s.keyS3.keyA;
    assign kB = s.keyS2.keyB & ~s.keyS3.keyB;
    assign kC = s.keyS2.keyC & ~s.keyS3.keyC;

    // zero-corrected pressure, never below zero
    assign p = (s.rawS2 > s.prm[dust_seq_pkg::F_ZERO]) ?
        s.rawS2 - s.prm[dust_seq_pkg::F_ZERO] : 10'h000;

    // cleaning conditions
    assign cnt = s.prm[dust_seq_pkg::F_COUNT][4:0];
    assign manLim = (cnt == 5'h00) ? dust_seq_pkg::NUM_OUT : cnt;
    assign consentOk = s.prm[dust_seq_pkg::F_CONSENT][0] |
        s.conS[1];
    assign fanOn = s.prm[dust_seq_pkg::F_FAN][0] ?
        (p != 10'h000) : s.fanS[1];
    assign runOk = (cnt != 5'h00) && consentOk &&
        (fanOn ? !s.pressLow : (s.postLeft != 7'h00));

    // phase limits
    assign pauseLen = 17'(s.prm[dust_seq_pkg::F_PAUSE] *
        dust_seq_pkg::TICKS_PER_SEC);
    assign pulseDone = s.phase >= {7'h00, s.prm[dust_seq_pkg::F_PULSE]};
    assign pauseDone = s.phase >= pauseLen;
    assign startIdx = s.manReq ? s.manSel :
        ((5'(s.curOut) >= cnt) ? 4'h0 : s.curOut);
    assign ovlHit = |(s.valve & s.ovlS2);

    // next-state logic for the whole block
    always_comb begin
        n = s;
        n.tickCnt = tick ? 24'h000000 : s.tickCnt + 24'h000001;
        n.keyS1 = keyPins;
        n.keyS2 = s.keyS1;
        n.keyS3 = s.keyS2;
        n.conS = {s.conS[0], consentPin};
        n.fanS = {s.fanS[0], fanContactPin};
        n.ovlS1 = overloadPins;
        n.ovlS2 = s.ovlS1;
        n.rawS1 = pressureRaw;
        n.rawS2 = s.rawS1;

        // set-mode inactivity timer
        if (kA || kB || kC) begin
            n.idle = 17'h00000;
        end else if (s.mode != dust_seq_pkg::MODE_RUN && tick) begin
            n.idle = s.idle + 17'h00001;
        end

        // menu and parameter editing
        case (s.mode)
            dust_seq_pkg::MODE_RUN: begin
                if (kC) begin
                    n.mode = dust_seq_pkg::MODE_MENU;
                    n.idle = 17'h00000;
                end
                if (kB) begin
                    n.ind.alarmMax = 1'b0;
                    n.ind.alarmOvl = 1'b0;
                end
            end
            dust_seq_pkg::MODE_MENU: begin
                if (kC) begin
                    if (s.func == dust_seq_pkg::F_FAN) begin
                        n.func = dust_seq_pkg::F_CONSENT;
                    end else if (s.func + 4'h1 == dust_seq_pkg::F_VOLT) begin
                        n.func = dust_seq_pkg::F_ZERO;
                    end else begin
                        n.func = s.func + 4'h1;
                    end
                end else if (kA) begin
                    n.mode = dust_seq_pkg::MODE_EDIT;
                end else if (kB) begin
                    n.mode = dust_seq_pkg::MODE_RUN;
                end
            end
            dust_seq_pkg::MODE_EDIT: begin
                if (kB) begin
                    n.mode = dust_seq_pkg::MODE_MENU;
                end else if (s.func == dust_seq_pkg::F_MANUAL) begin
                    if (kC) begin
                        n.manSel = dust_seq_pkg::nextOut(s.manSel,
                            manLim);
                    end
                    if (kA) begin
                        n.manReq = 1'b1;
                    end
                end else if (kC && s.prm[s.func] <
                    dust_seq_pkg::PRM_HI[s.func]) begin
                    n.prm[s.func] = s.prm[s.func] + 10'h001;
                end else if (kA && s.prm[s.func] >
                    dust_seq_pkg::PRM_LO[s.func]) begin
                    n.prm[s.func] = s.prm[s.func] - 10'h001;
                end
            end
            default: n.mode = dust_seq_pkg::MODE_RUN;
        endcase
        if (s.mode != dust_seq_pkg::MODE_RUN &&
            s.idle >= dust_seq_pkg::TIMEOUT_TICKS) begin
            n.mode = dust_seq_pkg::MODE_RUN;
        end
        if (5'(s.manSel) >= manLim) begin
            n.manSel = 4'h0;
        end

        // post-stop cycles and pressure hysteresis
        n.fanWas = fanOn;
        if (fanOn) begin
            n.postLeft = 7'h00;
        end else if (s.fanWas) begin
            n.postLeft = s.prm[dust_seq_pkg::F_POST][6:0];
        end
        if (!s.prm[dust_seq_pkg::F_PCTL][0]) begin
            n.pressLow = 1'b0;
        end else if (p < s.prm[dust_seq_pkg::F_STOP]) begin
            n.pressLow = 1'b1;
        end else if (p > s.prm[dust_seq_pkg::F_START]) begin
            n.pressLow = 1'b0;
        end

        // valve sequencer
        if (tick && s.seq != dust_seq_pkg::SEQ_IDLE && !(
            s.seq == dust_seq_pkg::SEQ_PAUSE && pauseDone)) begin
            n.phase = s.phase + 17'h00001;
        end
        case (s.seq)
            dust_seq_pkg::SEQ_PULSE: begin
                if (ovlHit) begin
                    n.ind.alarmOvl = 1'b1;
                    n.ind.ovlNum = 5'(s.ind.firedNum);
                end
                if (ovlHit || pulseDone) begin
                    n.valve = 16'h0000;
                    n.seq = dust_seq_pkg::SEQ_PAUSE;
                    n.phase = 17'h00000;
                    n.status[dust_seq_pkg::ST_PULSE] = 1'b1;
                    if (s.manual) begin
                        n.manual = 1'b0;
                    end else begin
                        n.curOut = dust_seq_pkg::nextOut(s.curOut,
                            cnt);
                        if (n.curOut == 4'h0 && !fanOn &&
                            s.postLeft != 7'h00) begin
                            n.postLeft = s.postLeft - 7'h01;
                        end
                    end
                end
            end
            dust_seq_pkg::SEQ_IDLE, dust_seq_pkg::SEQ_PAUSE: begin
                if (s.manReq || (runOk && (pauseDone ||
                    s.seq == dust_seq_pkg::SEQ_IDLE))) begin
                    n.seq = dust_seq_pkg::SEQ_PULSE;
                    n.phase = 17'h00000;
                    n.tickCnt = 24'h000000;
                    n.valve = 16'h0001 << startIdx;
                    n.manual = s.manReq;
                    n.manReq = 1'b0;
                    n.ind.firedNum = 5'(startIdx) + 5'h01;
                end
            end
            default: begin
                n.seq = dust_seq_pkg::SEQ_IDLE;
                n.valve = 16'h0000;
            end
        endcase

        // indicators
        if (!consentOk) begin
            n.ind.dispState = dust_seq_pkg::DSP_OFF;
        end else if (!fanOn) begin
            n.ind.dispState = dust_seq_pkg::DSP_FANOFF;
        end else if (s.pressLow) begin
            n.ind.dispState = dust_seq_pkg::DSP_LOWDP;
        end else begin
            n.ind.dispState = dust_seq_pkg::DSP_RUN;
        end
        n.ind.postBlink = consentOk && !fanOn && s.postLeft != 7'h00;
        n.ind.lowBlink = consentOk && fanOn && s.pressLow;
        n.ind.overRange = p > dust_seq_pkg::RANGE_TOP;
        n.ind.pressure = p;
        n.ind.pauseTicks = (s.seq == dust_seq_pkg::SEQ_PAUSE) ?
            s.phase : 17'h00000;
        if (p > s.prm[dust_seq_pkg::F_MAX]) begin
            n.ind.alarmMax = 1'b1;
        end

        // register port: read data one cycle later, read clears status
        n.rdData = 16'h0000;
        if (regRd) begin
            if (regAddr < dust_seq_pkg::NUM_PRM) begin
                n.rdData = {6'h00, s.prm[regAddr]};
            end else if (regAddr == dust_seq_pkg::REG_STATUS) begin
                n.rdData = {12'h000, s.status};
                n.status = 4'h0;
            end else if (regAddr == dust_seq_pkg::REG_MASK) begin
                n.rdData = {12'h000, s.mask};
            end else begin
                n.rdData = {s.ind.firedNum, s.ind.dispState,
                    s.seq, s.mode, 1'b0, s.curOut};
            end
        end
        if (regWr) begin
            if (regAddr < dust_seq_pkg::NUM_PRM) begin
                n.prm[regAddr] = dust_seq_pkg::clampPrm(regAddr,
                    regWrData[9:0]);
            end else if (regAddr == dust_seq_pkg::REG_MASK) begin
                n.mask = regWrData[3:0];
            end
        end

        // events set status after any clear, so a set wins
        if (s.seq == dust_seq_pkg::SEQ_PULSE && (ovlHit || pulseDone)) begin
            n.status[dust_seq_pkg::ST_PULSE] = 1'b1;
        end
        if (n.ind.alarmMax && !s.ind.alarmMax) begin
            n.status[dust_seq_pkg::ST_MAXA] = 1'b1;
        end
        if (ovlHit && s.seq == dust_seq_pkg::SEQ_PULSE) begin
            n.status[dust_seq_pkg::ST_OVL] = 1'b1;
        end
        if (n.ind.dispState != dust_seq_pkg::DSP_RUN &&
            s.ind.dispState == dust_seq_pkg::DSP_RUN) begin
            n.status[dust_seq_pkg::ST_HALT] = 1'b1;
        end
    end

    // state register with synchronous reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '0;
            s.prm <= dust_seq_pkg::PRM_RST;
            s.func <= dust_seq_pkg::F_CONSENT;
        end else begin
            s <= n;
        end
    end

    // outputs straight from the state
    assign valveOut = s.valve;
    assign ind = s.ind;
    assign menuMode = s.mode;
    assign menuFunc = s.func;
    assign regRdData = s.rdData;
    assign irq = |(s.status & s.mask);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_one_valve: assert property ($onehot0(valveOut))
        else $error("more than one valve energised");
    chk_pulse_end: assert property (
        s.seq == dust_seq_pkg::SEQ_PULSE && pulseDone && !ovlHit
        |=> valveOut == 16'h0000 &&
        s.seq == dust_seq_pkg::SEQ_PAUSE)
        else $error("pulse did not end at its set length");
    chk_pause_hold: assert property (
        s.seq == dust_seq_pkg::SEQ_PAUSE && !pauseDone && !s.manReq
        |=> valveOut == 16'h0000)
        else $error("valve fired during pause");
    chk_consent_off: assert property (
        !s.prm[dust_seq_pkg::F_CONSENT][0] && !s.conS[1]
        |=> ind.dispState == dust_seq_pkg::DSP_OFF)
        else $error("open consent not shown as off");
    chk_fan_off: assert property (
        consentOk && !fanOn
        |=> ind.dispState == dust_seq_pkg::DSP_FANOFF)
        else $error("fan off not shown");
    // a key B press right after the excess may clear the alarm
    chk_max_alarm: assert property (
        p > s.prm[dust_seq_pkg::F_MAX]
        |=> ind.alarmMax ##1 (ind.alarmMax || $past(kB)))
        else $error("maximum pressure alarm not held");
    chk_over_range: assert property (
        $rose(p > dust_seq_pkg::RANGE_TOP) |=> ind.overRange)
        else $error("over-range not flagged");
    chk_ovl_num: assert property (
        s.seq == dust_seq_pkg::SEQ_PULSE && ovlHit
        |=> ind.alarmOvl && ind.ovlNum == $past(s.ind.firedNum))
        else $error("overload alarm lacks output number");
    chk_set_timeout: assert property (
        s.mode != dust_seq_pkg::MODE_RUN &&
        s.idle >= dust_seq_pkg::TIMEOUT_TICKS
        |=> menuMode == dust_seq_pkg::MODE_RUN)
        else $error("set mode did not time out");
    chk_key_menu: assert property (
        s.mode == dust_seq_pkg::MODE_RUN && kC
        |=> menuMode == dust_seq_pkg::MODE_MENU)
        else $error("key C did not open the menu");
    chk_manual_fire: assert property (
        s.manReq && s.seq != dust_seq_pkg::SEQ_PULSE
        |=> valveOut == 16'h0001 << $past(s.manSel))
        else $error("manual pulse not on the selected output");
    chk_low_stop: assert property (
        s.pressLow && fanOn && s.seq != dust_seq_pkg::SEQ_PULSE &&
        !s.manReq |=> valveOut == 16'h0000)
        else $error("valve fired while pressure is low");
    chk_fired_num: assert property (
        $rose(|valveOut)
        |-> valveOut == 16'h0001 << (ind.firedNum - 5'h01))
        else $error("shown output number differs from fired valve");
    chk_count_limit: assert property (
        (s.seq == dust_seq_pkg::SEQ_IDLE || pauseDone &&
        s.seq == dust_seq_pkg::SEQ_PAUSE) && runOk && !s.manReq
        |=> ind.firedNum <= $past(cnt))
        else $error("output beyond the active count fired");
endmodule : dust_filter_cleaning_sequencer

// ### verif/valve_field_model.sv
`timescale 1ns/1ps
module valve_field_model (
    // clock and valve drive
    input wire logic core_clk,
    input wire logic [15:0] valveOut,
    // scenario controls
    input wire logic fanOn,
    input wire logic consentOn,
    input wire logic ovlOn,
    input wire logic [9:0] pressure,
    // field pins
    output logic consentPin,
    output logic fanContactPin,
    output logic [15:0] overloadPins,
    output logic [9:0] pressureRaw,
    // observed activity
    output int pulses,
    output logic multiHot
);
    logic [15:0] lastV;

    // contacts and transducer simply follow the scenario
    assign consentPin = consentOn;
    assign fanContactPin = fanOn;
    assign pressureRaw = pressure;
    // a shorted coil only draws overcurrent while energised
    assign overloadPins = ovlOn ? valveOut : 16'h0000;

    // start from a quiet field
    initial begin
        lastV = 16'h0000;
        pulses = 0;
        multiHot = 1'b0;
    end

    // count pulse starts and catch two coils on at once
    always @(posedge core_clk) begin
        if (valveOut != 16'h0000 && lastV == 16'h0000) begin
            pulses <= pulses + 1;
        end
        if ($countones(valveOut) > 1) begin
            multiHot <= 1'b1;
        end
        lastV <= valveOut;
    end
endmodule : valve_field_model

// ### verif/dust_filter_cleaning_sequencer_test.sv
`timescale 1ns/1ps
module dust_filter_cleaning_sequencer_test;
    // clock, reset and register port
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdData;
    // field side
    dust_seq_pkg::keys_t keyPins = 3'b000;
    logic consentPin;
    logic fanContactPin;
    logic [15:0] overloadPins;
    logic [15:0] valveOut;
    logic [9:0] pressureRaw;
    dust_seq_pkg::indicator_t ind;
    dust_seq_pkg::mode_t menuMode;
    logic [3:0] menuFunc;
    logic irq;
    logic fanOn = 1'b1;
    logic consentOn = 1'b1;
    logic ovlOn = 1'b0;
    logic [9:0] pressure = 10'h000;
    logic multiHot;
    int pulses;
    int error_cnt = 0;
    int compares = 0;
    int n, w, p, k;
    logic [15:0] d;
    logic [15:0] dflt [0:12] = '{16'h0000, 16'h000a, 16'h000a, 16'h0010,
        16'h000a, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064,
        16'h0096, 16'h012c, 16'h0000};
    // address, written value, value read back
    logic [15:0] clampTab [0:7][0:2] = '{'{16'h1, 16'h0, 16'h5},
        '{16'h1, 16'h258, 16'h1f4}, '{16'h2, 16'h0, 16'h1},
        '{16'h2, 16'h3e8, 16'h3e7}, '{16'h3, 16'h11, 16'h10},
        '{16'h4, 16'h64, 16'h63}, '{16'h5, 16'h3, 16'h0},
        '{16'h7, 16'h5, 16'h0}};

    // 20 MHz core clock
    always #25 core_clk = ~core_clk;

    dust_filter_cleaning_sequencer #(.TICK_CYCLES(10))
        dust_filter_cleaning_sequencer_i (.core_clk(core_clk), .rst(rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .keyPins(keyPins),
        .consentPin(consentPin), .fanContactPin(fanContactPin),
        .overloadPins(overloadPins), .pressureRaw(pressureRaw),
        .valveOut(valveOut), .ind(ind), .menuMode(menuMode),
        .menuFunc(menuFunc), .irq(irq));

    valve_field_model valve_field_model_i (.core_clk(core_clk),
        .valveOut(valveOut), .fanOn(fanOn), .consentOn(consentOn),
        .ovlOn(ovlOn), .pressure(pressure), .consentPin(consentPin),
        .fanContactPin(fanContactPin), .overloadPins(overloadPins),
        .pressureRaw(pressureRaw), .pulses(pulses), .multiHot(multiHot));

    // verdict and end of run
    task automatic stop_test();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge core_clk);
        regAddr <= a[3:0];
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] v);
        @(posedge core_clk);
        regAddr <= a[3:0];
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        v = regRdData;
    endtask : rd

    // bounded wait for any valve on (on=1) or all off, in cycles
    task automatic waitv(input logic on, input int lim, output int c);
        c = 0;
        while ((valveOut != 16'h0000) !== on) begin
            @(negedge core_clk);
            c++;
            if (c > lim) begin
                error_cnt++;
                $display("[FAIL] t=%0t valves %h exp %h", $time, valveOut, on);
                stop_test();
            end
        end
    endtask : waitv

    task automatic key(input logic [2:0] kv);
        @(posedge core_clk);
        keyPins <= kv;
        repeat (6) @(posedge core_clk);
        keyPins <= 3'b000;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
    endtask : key

    // display shows the halt cause and no pulse starts for a full pause
    task automatic halt_chk(input dust_seq_pkg::disp_t e);
        repeat (20) @(negedge core_clk);
        chk(ind.dispState, e);
        p = pulses;
        repeat (1500) @(negedge core_clk);
        chk(pulses, p);
    endtask : halt_chk

    // watchdog against a hang
    initial begin
        repeat (90000) @(posedge core_clk);
        error_cnt++;
        $display("[FAIL] t=%0t hang %h exp %h", $time, 1'b1, 1'b0);
        stop_test();
    end

    // main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        waitv(1'b1, 20, n);
        chk(valveOut, 16'h0001);
        chk(ind.firedNum, 5'h01);
        for (k = 0; k < 13; k++) begin
            rd(16'(k), d);
            chk(d, dflt[k]);
        end
        for (k = 0; k < 8; k++) begin
            wr(clampTab[k][0], clampTab[k][1]);
            rd(clampTab[k][0], d);
            chk(d, clampTab[k][2]);
        end
        wr(16'h1, 16'h5);
        wr(16'h2, 16'h1);
        wr(16'h3, 16'h3);
        wr(16'h4, 16'h0);
        wr(16'he, 16'h1);
        waitv(1'b0, 200, n);
        waitv(1'b1, 12000, n);
        for (k = 0; k < 4; k++) begin
            chk(valveOut, 16'h1 << ((k + 1) % 3));
            chk(ind.firedNum, 5'((k + 1) % 3 + 1));
            waitv(1'b0, 100, w);
            chk(w, 51);
            if (k == 0) begin
                chk(irq, 1'b1);
                rd(16'hd, d);
                chk(d[0], 1'b1);
                chk(irq, 1'b0);
                wr(16'he, 16'h0);
            end
            if (k == 1) begin
                repeat (500) @(negedge core_clk);
                chk(ind.pauseTicks > 17'h2f &&
                    ind.pauseTicks < 17'h34, 1);
            end
            waitv(1'b1, 1100, n);
            if (k == 2) begin
                chk(n > 994 && n < 1006, 1);
            end
        end
        waitv(1'b0, 100, w);
        @(posedge core_clk);
        consentOn <= 1'b0;
        halt_chk(dust_seq_pkg::DSP_OFF);
        consentOn <= 1'b1;
        waitv(1'b1, 1100, n);
        waitv(1'b0, 100, w);
        fanOn <= 1'b0;
        halt_chk(dust_seq_pkg::DSP_FANOFF);
        fanOn <= 1'b1;
        waitv(1'b1, 1100, n);
        wr(16'h4, 16'h1);
        fanOn <= 1'b0;
        waitv(1'b0, 100, w);
        waitv(1'b1, 1100, n);
        chk(ind.postBlink, 1'b1);
        for (n = 0; n < 200 && ind.postBlink !== 1'b0; n++)
            @(negedge core_clk);
        chk(ind.postBlink, 1'b0);
        halt_chk(dust_seq_pkg::DSP_FANOFF);
        fanOn <= 1'b1;
        wr(16'h4, 16'h0);
        wr(16'h8, 16'h14);
        pressure <= 10'h078;
        repeat (50) @(negedge core_clk);
        chk(ind.pressure, 10'h064);
        pressure <= 10'h3ff;
        repeat (50) @(negedge core_clk);
        chk(ind.overRange, 1'b1);
        chk(ind.alarmMax, 1'b1);
        pressure <= 10'h078;
        repeat (50) @(negedge core_clk);
        chk(ind.alarmMax, 1'b1);
        key(3'b010);
        chk(ind.alarmMax, 1'b0);
        wr(16'h6, 16'h1);
        wr(16'h9, 16'h32);
        wr(16'ha, 16'h64);
        pressure <= 10'h028;
        repeat (50) @(negedge core_clk);
        waitv(1'b0, 100, w);
        halt_chk(dust_seq_pkg::DSP_LOWDP);
        chk(ind.lowBlink, 1'b1);
        pressure <= 10'h08c;
        waitv(1'b1, 1100, n);
        wr(16'h6, 16'h0);
        waitv(1'b0, 100, w);
        ovlOn <= 1'b1;
        waitv(1'b1, 1100, n);
        d = valveOut;
        waitv(1'b0, 100, w);
        ovlOn <= 1'b0;
        for (k = 0; k < 16; k++)
            if (d[k]) p = k + 1;
        chk(w < 51, 1);
        chk(ind.alarmOvl, 1'b1);
        chk(ind.ovlNum, 5'(p));
        key(3'b001);
        chk(menuMode, dust_seq_pkg::MODE_MENU);
        chk(menuFunc, 4'h0);
        key(3'b001);
        chk(menuFunc, 4'h1);
        key(3'b100);
        chk(menuMode, dust_seq_pkg::MODE_EDIT);
        key(3'b001);
        rd(16'h1, d);
        chk(d, 16'h0006);
        key(3'b100);
        rd(16'h1, d);
        chk(d, 16'h0005);
        key(3'b010);
        chk(menuMode, dust_seq_pkg::MODE_MENU);
        // manual fire: pick output 2, fire it at the start of a pause
        for (k = 0; k < 4; k++)
            key(3'b001);
        chk(menuFunc, 4'h5);
        key(3'b100);
        key(3'b001);
        waitv(1'b1, 1100, n);
        waitv(1'b0, 100, w);
        key(3'b100);
        chk(valveOut, 16'h0002);
        chk(ind.firedNum, 5'h02);
        key(3'b010);
        chk(menuMode, dust_seq_pkg::MODE_MENU);
        key(3'b010);
        chk(menuMode, dust_seq_pkg::MODE_RUN);
        chk(multiHot, 1'b0);
        stop_test();
    end
endmodule : dust_filter_cleaning_sequencer_test
